// File: src/rrl_pkg.sv
// Shared constants and types for the refresh and RAS lock link
package rrl_pkg;
  // ==========================================================
  // Clock and link timing
  // ==========================================================
  localparam int CLK_PS      = 25000;
  localparam int CK_DIV      = 4;
  localparam int TW          = 8;
  localparam int T_RCD_PS    = 18000;
  localparam int T_RAS_PS    = 42000;
  localparam int T_RC_PS     = 60000;
  localparam int T_RP_PS     = 18000;
  localparam int T_RRD_PS    = 10000;
  localparam int T_RFCAB_PS  = 280000;
  localparam int T_RFCPB_PS  = 140000;
  localparam int T_WR_PS     = 18000;
  localparam int T_WTR_PS    = 10000;
  localparam int N_RCD   = (T_RCD_PS + CLK_PS - 1) / CLK_PS;
  localparam int N_RAS   = (T_RAS_PS + CLK_PS - 1) / CLK_PS;
  localparam int N_RC    = (T_RC_PS + CLK_PS - 1) / CLK_PS;
  localparam int N_RP    = (T_RP_PS + CLK_PS - 1) / CLK_PS;
  localparam int N_RRD   = (T_RRD_PS + CLK_PS - 1) / CLK_PS;
  localparam int N_RFCAB = (T_RFCAB_PS + CLK_PS - 1) / CLK_PS;
  localparam int N_RFCPB = (T_RFCPB_PS + CLK_PS - 1) / CLK_PS;
  localparam int N_WR    = (T_WR_PS + CLK_PS - 1) / CLK_PS;
  localparam int N_WTR   = (T_WTR_PS + CLK_PS - 1) / CLK_PS;
  // Auto-precharge delays in link clocks
  localparam int NRTP_NCK = 8;
  localparam int NWR_NCK  = 8;
  localparam int BL32_NCK = 8;
  // ==========================================================
  // First-edge opcodes on CA[4:0]
  // ==========================================================
  localparam logic [4:0] OP_ACT = 5'h01;
  localparam logic [4:0] OP_RD  = 5'h02;
  localparam logic [4:0] OP_WR  = 5'h04;
  localparam logic [4:0] OP_REF = 5'h08;
  localparam logic [4:0] OP_PRE = 5'h10;
  localparam logic [4:0] OP_SRX = 5'h14;
  localparam int NBANK = 8;

  typedef enum logic [2:0] {
    C_ACT, C_RDA, C_WRA, C_WR, C_PRE, C_REFPB, C_REFAB, C_SRX
  } rrl_cmd_type;
endpackage : rrl_pkg

// File: src/rrl_link_if.sv
// Command link between controller end and memory end
`timescale 1ns/100ps
interface rrl_link_if;
  logic       ck;
  logic       cs;
  logic [5:0] ca;
  modport ctl (output ck, output cs, output ca);
  modport dev (input ck, input cs, input ca);
endinterface : rrl_link_if

// File: src/rrl_dev_end.sv
// Memory end: command decode, RAS lock, refresh counters
`timescale 1ns/100ps
module rrl_dev_end import rrl_pkg::*; #(
  parameter int ROW_W    = 16,
  parameter int P_RAS    = N_RAS,
  parameter int P_RFCAB  = N_RFCAB,
  parameter int P_RFCPB  = N_RFCPB
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [7:0]       i_mr_nrtp,
  input  wire logic [7:0]       i_mr_nwr,
  output logic [NBANK-1:0]      o_bank_open,
  output logic [NBANK-1:0]      o_bank_busy,
  output logic                  o_ref_pulse,
  output logic                  o_ref_all,
  output logic [2:0]            o_ref_bank,
  output logic [ROW_W-1:0]      o_ref_row,
  output logic [2:0]            o_bank_cnt,
  rrl_link_if.dev               link
);
  // ==========================================================
  // Pin synchronisers and edge detect
  // ==========================================================
  logic       ck_s1_reg, ck_s2_reg, ck_s3_reg;
  logic       cs_s1_reg, cs_s2_reg;
  logic [5:0] ca_s1_reg, ca_s2_reg;
  logic       rise;
  always_ff @(posedge i_clk) begin
    ck_s1_reg <= link.ck;
    ck_s2_reg <= ck_s1_reg;
    ck_s3_reg <= ck_s2_reg;
    cs_s1_reg <= link.cs;
    cs_s2_reg <= cs_s1_reg;
    ca_s1_reg <= link.ca;
    ca_s2_reg <= ca_s1_reg;
  end
  assign rise = ck_s2_reg & ~ck_s3_reg;

  // ==========================================================
  // Two-edge decode
  // ==========================================================
  logic       second_reg;
  logic [5:0] w1_reg;
  logic       cmd_v;
  logic [2:0] cmd_bank;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      second_reg <= 1'b0;
      w1_reg     <= 6'h00;
    end else if (rise) begin
      if (second_reg) begin
        second_reg <= 1'b0;
      end else if (cs_s2_reg) begin
        second_reg <= 1'b1;
        w1_reg     <= ca_s2_reg;
      end
    end
  end
  assign cmd_v    = rise & second_reg;
  assign cmd_bank = ca_s2_reg[2:0];

  logic is_ref, is_refab, is_refpb, is_act, is_pre, is_srx, is_rda, is_wra;
  assign is_ref   = cmd_v && w1_reg[4:0] == OP_REF;
  assign is_refab = is_ref && w1_reg[5];
  assign is_refpb = is_ref && !w1_reg[5];
  assign is_act   = cmd_v && w1_reg[4:0] == OP_ACT;
  assign is_pre   = cmd_v && w1_reg[4:0] == OP_PRE;
  assign is_srx   = cmd_v && w1_reg[4:0] == OP_SRX;
  assign is_rda   = cmd_v && w1_reg[4:0] == OP_RD && w1_reg[5];
  assign is_wra   = cmd_v && w1_reg[4:0] == OP_WR && w1_reg[5];

  // ==========================================================
  // Per-bank RAS lock and refresh busy
  // ==========================================================
  genvar b;
  generate
    for (b = 0; b < NBANK; b++) begin : g_bank
      logic [TW-1:0] ras_reg;
      logic [7:0]    ap_reg;
      logic          ap_pend_reg;
      logic [TW-1:0] busy_reg;
      logic          hit;
      assign hit = cmd_bank == 3'(b);
      always_ff @(posedge i_clk) begin
        if (i_rst || (is_act && hit)) begin
          ras_reg <= '0;
        end else if (ras_reg != '1) begin
          ras_reg <= ras_reg + 1'b1;
        end
      end
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          o_bank_open[b] <= 1'b0;
          ap_pend_reg    <= 1'b0;
          ap_reg         <= 8'h00;
        end else if (is_act && hit) begin
          o_bank_open[b] <= 1'b1;
          ap_pend_reg    <= 1'b0;
        end else if ((is_rda || is_wra) && hit) begin
          ap_pend_reg <= 1'b1;
          ap_reg      <= is_rda ? i_mr_nrtp : i_mr_nwr;
        end else if (is_pre && (hit || w1_reg[5])) begin
          o_bank_open[b] <= 1'b0;
          ap_pend_reg    <= 1'b0;
        end else if (ap_pend_reg) begin
          if (rise && ap_reg != 8'h00) begin
            ap_reg <= ap_reg - 8'h01;
          end
          if (ap_reg == 8'h00 && ras_reg >= TW'(P_RAS)) begin
            o_bank_open[b] <= 1'b0;
            ap_pend_reg    <= 1'b0;
          end
        end
      end
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          busy_reg <= '0;
        end else if (is_refab) begin
          busy_reg <= TW'(P_RFCAB);
        end else if (is_refpb && hit) begin
          busy_reg <= TW'(P_RFCPB);
        end else if (busy_reg != '0) begin
          busy_reg <= busy_reg - 1'b1;
        end
      end
      assign o_bank_busy[b] = busy_reg != '0;
    end
  endgenerate

  // ==========================================================
  // Bank and row counters
  // ==========================================================
  logic [ROW_W-1:0] row_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst || is_srx || is_refab) begin
      o_bank_cnt <= 3'h0;
    end else if (is_refpb) begin
      o_bank_cnt <= o_bank_cnt + 3'h1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      row_reg <= '0;
    end else if (is_refab || (is_refpb && o_bank_cnt == 3'h7)) begin
      row_reg <= row_reg + 1'b1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ref_pulse <= 1'b0;
      o_ref_all   <= 1'b0;
      o_ref_bank  <= 3'h0;
      o_ref_row   <= '0;
    end else begin
      o_ref_pulse <= is_ref;
      if (is_ref) begin
        o_ref_all  <= is_refab;
        o_ref_bank <= cmd_bank;
        o_ref_row  <= row_reg;
      end
    end
  end
endmodule : rrl_dev_end

// File: src/rrl_ctl_end.sv
// Controller end: command timing, refresh tracking, link driver
`timescale 1ns/100ps
module rrl_ctl_end import rrl_pkg::*; #(
  parameter int P_RCD   = N_RCD,
  parameter int P_RC    = N_RC,
  parameter int P_RP    = N_RP,
  parameter int P_RRD   = N_RRD,
  parameter int P_RFCAB = N_RFCAB,
  parameter int P_RFCPB = N_RFCPB,
  parameter int P_WR    = N_WR,
  parameter int P_WTR   = N_WTR,
  parameter int P_NRTP  = NRTP_NCK
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_bl32,
  input  wire logic        i_req_valid,
  input  rrl_cmd_type      i_req_cmd,
  input  wire logic [2:0]  i_req_bank,
  output logic             o_req_ready,
  output logic [NBANK-1:0] o_bank_open,
  output logic [NBANK-1:0] o_ref_done,
  output logic [2:0]       o_bank_cnt,
  rrl_link_if.ctl          link
);
  // ==========================================================
  // Link clock divider and word sequencer
  // ==========================================================
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_W1   = 2'b01,
    ST_W2   = 2'b11
  } rrl_st_type;

  rrl_st_type st_reg;
  logic [1:0] ph_reg;
  logic       cs_reg;
  logic [5:0] ca_reg;
  logic [2:0] bank_hold_reg;
  logic       slot;
  logic       acc;

  assign slot = ph_reg == 2'h3;
  assign acc  = o_req_ready & i_req_valid;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ph_reg <= 2'h0;
    end else begin
      ph_reg <= ph_reg + 2'h1;
    end
  end
  assign link.ck = ph_reg[1];
  assign link.cs = cs_reg;
  assign link.ca = ca_reg;

  function automatic logic [5:0] word1(rrl_cmd_type c);
    case (c)
      C_ACT:   word1 = {1'b0, OP_ACT};
      C_RDA:   word1 = {1'b1, OP_RD};
      C_WRA:   word1 = {1'b1, OP_WR};
      C_WR:    word1 = {1'b0, OP_WR};
      C_PRE:   word1 = {1'b0, OP_PRE};
      C_REFPB: word1 = {1'b0, OP_REF};
      C_REFAB: word1 = {1'b1, OP_REF};
      C_SRX:   word1 = {1'b0, OP_SRX};
      default: word1 = 6'h00;
    endcase
  endfunction : word1

  // Words change while ck is low, stable at its rising edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg        <= ST_IDLE;
      cs_reg        <= 1'b0;
      ca_reg        <= 6'h00;
      bank_hold_reg <= 3'h0;
    end else if (slot) begin
      case (st_reg)
        ST_W1: begin
          st_reg <= ST_W2;
          cs_reg <= 1'b0;
          ca_reg <= {3'h0, bank_hold_reg};
        end
        default: begin
          if (acc) begin
            st_reg        <= ST_W1;
            cs_reg        <= 1'b1;
            ca_reg        <= word1(i_req_cmd);
            bank_hold_reg <= i_req_bank;
          end else begin
            st_reg <= ST_IDLE;
            cs_reg <= 1'b0;
            ca_reg <= 6'h00;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Command events
  // ==========================================================
  logic ev_act, ev_pre, ev_ap, ev_wr, ev_refpb, ev_refab, ev_srx;
  assign ev_act   = acc && i_req_cmd == C_ACT;
  assign ev_pre   = acc && i_req_cmd == C_PRE;
  assign ev_ap    = acc && (i_req_cmd == C_RDA || i_req_cmd == C_WRA);
  assign ev_wr    = acc && (i_req_cmd == C_WR || i_req_cmd == C_WRA);
  assign ev_refpb = acc && i_req_cmd == C_REFPB;
  assign ev_refab = acc && i_req_cmd == C_REFAB;
  assign ev_srx   = acc && i_req_cmd == C_SRX;

  // ==========================================================
  // Global elapsed-time counters
  // ==========================================================
  logic [TW-1:0] since_act_reg, since_refab_reg, since_refpb_reg;
  logic [TW-1:0] since_wr_reg;
  // Saturating step so long-idle timers never wrap back to short
  function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
    sat_inc = (v == '1) ? v : v + 1'b1;
  endfunction : sat_inc
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      since_act_reg   <= '1;
      since_refab_reg <= '1;
      since_refpb_reg <= '1;
      since_wr_reg    <= '1;
    end else begin
      since_act_reg   <= ev_act ? '0 : sat_inc(since_act_reg);
      since_refab_reg <= ev_refab ? '0 : sat_inc(since_refab_reg);
      since_refpb_reg <= ev_refpb ? '0 : sat_inc(since_refpb_reg);
      since_wr_reg    <= ev_wr ? '0 : sat_inc(since_wr_reg);
    end
  end

  // ==========================================================
  // Per-bank state and timing
  // ==========================================================
  logic [NBANK-1:0] act_ok, ap_ok, pre_ok, ref_ok;
  genvar b;
  generate
    for (b = 0; b < NBANK; b++) begin : g_bank
      logic [TW-1:0] act_t_reg, pre_t_reg, rpb_t_reg;
      logic          hit;
      assign hit = i_req_bank == 3'(b);
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          act_t_reg <= '1;
        end else if (ev_act && hit) begin
          act_t_reg <= '0;
        end else if (act_t_reg != '1) begin
          act_t_reg <= act_t_reg + 1'b1;
        end
      end
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          pre_t_reg <= '1;
        end else if ((ev_pre || ev_ap) && hit) begin
          pre_t_reg <= '0;
        end else if (pre_t_reg != '1) begin
          pre_t_reg <= pre_t_reg + 1'b1;
        end
      end
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          rpb_t_reg <= '1;
        end else if (ev_refpb && hit) begin
          rpb_t_reg <= '0;
        end else if (rpb_t_reg != '1) begin
          rpb_t_reg <= rpb_t_reg + 1'b1;
        end
      end
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          o_bank_open[b] <= 1'b0;
        end else if (ev_act && hit) begin
          o_bank_open[b] <= 1'b1;
        end else if ((ev_pre || ev_ap) && hit) begin
          o_bank_open[b] <= 1'b0;
        end
      end
      assign act_ok[b] = !o_bank_open[b]
        && act_t_reg >= TW'(P_RC)
        && pre_t_reg >= TW'(P_RP)
        && rpb_t_reg >= TW'(P_RFCPB);
      assign ap_ok[b]  = o_bank_open[b]
        && act_t_reg >= TW'(P_RCD);
      assign pre_ok[b] = pre_t_reg >= TW'(P_RP);
      assign ref_ok[b] = !o_bank_open[b]
        && pre_t_reg >= TW'(P_RP)
        && !o_ref_done[b];
    end
  endgenerate

  // ==========================================================
  // Per-bank refresh set and bank counter
  // ==========================================================
  always_ff @(posedge i_clk) begin
    if (i_rst || ev_srx || ev_refab) begin
      o_ref_done <= '0;
    end else if (ev_refpb) begin
      if ((o_ref_done | (8'h01 << i_req_bank)) == 8'hFF) begin
        o_ref_done <= '0;
      end else begin
        o_ref_done <= o_ref_done | (8'h01 << i_req_bank);
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst || ev_srx || ev_refab) begin
      o_bank_cnt <= 3'h0;
    end else if (ev_refpb) begin
      o_bank_cnt <= o_bank_cnt + 3'h1;
    end
  end

  // ==========================================================
  // Request admission
  // ==========================================================
  logic ref_gap, rda_ok, ok;
  assign ref_gap = since_refab_reg >= TW'(P_RFCAB)
                && since_refpb_reg >= TW'(P_RFCPB);
  // Write recovery covered by time since write plus nRTP, plus 8 link clocks (32 cycles) at BL32; tWTR checked alone
  assign rda_ok = since_wr_reg >= TW'(P_WTR)
    && (10'(since_wr_reg) + 10'(P_NRTP * CK_DIV)
        + (i_bl32 ? 10'(BL32_NCK * CK_DIV) : 10'h000)
        >= 10'(P_WR));

  always_comb begin
    case (i_req_cmd)
      C_ACT:   ok = act_ok[i_req_bank] && ref_gap
                 && since_act_reg >= TW'(P_RRD);
      C_RDA:   ok = ap_ok[i_req_bank] && rda_ok;
      C_WRA:   ok = ap_ok[i_req_bank];
      C_WR:    ok = o_bank_open[i_req_bank];
      C_PRE:   ok = pre_ok[i_req_bank];
      C_REFPB: ok = ref_ok[i_req_bank] && ref_gap
                 && since_act_reg >= TW'(P_RRD);
      C_REFAB: ok = o_bank_open == '0
                 && (&pre_ok) && ref_gap;
      C_SRX:   ok = ref_gap;
      default: ok = 1'b0;
    endcase
  end
  assign o_req_ready = slot && st_reg != ST_W1 && ok;
endmodule : rrl_ctl_end

// File: dv/rrl_chk.sv
// Link framing and refresh decode assertions for the joined ends
`timescale 1ns/100ps
module rrl_chk import rrl_pkg::*; (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        ck,
  input  wire logic        cs,
  input  wire logic [5:0]  ca,
  input  wire logic        o_ref_pulse,
  input  wire logic        o_ref_all,
  input  wire logic [2:0]  o_ref_bank,
  input  wire logic [15:0] o_ref_row,
  input  wire logic [2:0]  o_bank_cnt
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ==========================================================
  // Helper state
  // ==========================================================
  logic [5:0]  w1_reg;
  logic [8:0]  cmd_reg;
  logic        pls_reg;
  logic [2:0]  base_reg;
  logic        all_reg;
  logic [15:0] row_reg;

  // Word one, then word one with its bank once word two shows
  always_ff @(posedge i_clk) begin
    if ($rose(cs)) w1_reg <= ca;
  end
  always_ff @(posedge i_clk) begin
    if ($fell(cs)) cmd_reg <= {w1_reg, ca[2:0]};
  end
  always_ff @(posedge i_clk) begin
    pls_reg <= o_ref_pulse;
  end
  // Count value from before the latest refresh
  always_ff @(posedge i_clk) begin
    if (!o_ref_pulse && !pls_reg) base_reg <= o_bank_cnt;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      all_reg <= 1'b0;
      row_reg <= 16'h0000;
    end else if (o_ref_pulse) begin
      all_reg <= o_ref_all;
      row_reg <= o_ref_row;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  cs_width_a: assert property ($rose(cs) |-> cs[*4] ##1 !cs)
    else $error("chip select word not one link clock long");
  word1_edge_a: assert property ($rose(cs) |-> !ck ##1 !ck ##1 ck)
    else $error("first word not centred on a link clock rise");
  word2_a: assert property ($fell(cs) |-> (!cs && ca[5:3] == 3'h0)[*4])
    else $error("second word malformed");
  ca_hold_a: assert property ($changed({cs, ca}) |-> !ck)
    else $error("command lines moved while link clock high");
  ref_only_a: assert property (o_ref_pulse |-> cmd_reg[7:3] == OP_REF)
    else $error("refresh decoded from another opcode");
  ref_kind_a: assert property (o_ref_pulse |-> o_ref_all == cmd_reg[8])
    else $error("refresh kind does not follow bit five");
  ref_bank_a: assert property (o_ref_pulse && !o_ref_all |->
    o_ref_bank == cmd_reg[2:0])
    else $error("per-bank refresh took wrong bank");
  cnt_step_a: assert property (pls_reg |-> o_bank_cnt ==
    (o_ref_all ? 3'h0 : 3'(base_reg + 3'h1)))
    else $error("bank counter step wrong");
  row_step_a: assert property (o_ref_pulse && all_reg |->
    o_ref_row == 16'(row_reg + 16'h0001))
    else $error("row not incremented after all-bank refresh");
endmodule : rrl_chk

// File: dv/refresh_and_ras_lock_logic_test.sv
// Self-checking bench joining the controller and memory ends
`timescale 1ns/100ps
module refresh_and_ras_lock_logic_test import rrl_pkg::*;;
  localparam int RAS  = 80;
  localparam int RFAB = 40;
  localparam int RFPB = 20;
  localparam int NR   = 22;
  // Bank sequence, expected counter after each, expected row
  int bk[NR]   = '{0,1,2,3,4,5,6,7,6,7,1,3,5,2,0,4,0,1,2,0,6,7};
  int ecnt[NR] = '{1,2,3,4,5,6,7,0,1,2,3,4,5,6,7,0,1,2,3,0,1,2};
  int erow[NR] = '{0,0,0,0,0,0,0,0,1,1,1,1,1,1,1,1,2,2,2,2,3,3};

  logic        i_clk       = 1'b0;
  logic        i_rst       = 1'b1;
  logic        i_req_valid = 1'b0;
  rrl_cmd_type i_req_cmd   = C_ACT;
  logic [2:0]  i_req_bank  = 3'h0;
  logic [7:0]  i_mr_nwr    = 8'h08;
  logic        i_bl32      = 1'b0;
  logic        rdy;
  logic [7:0]  c_open, c_done, d_open, d_busy;
  logic [2:0]  c_cnt, d_cnt, bank;
  logic        pulse, all;
  logic [15:0] row;
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          dur = 0;
  int          t_acc = 0;

  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) cyc++;
  always @(posedge i_clk) if (d_open[2] === 1'b1) dur <= dur + 1;

  // ==========================================================
  // Design and checker
  // ==========================================================
  rrl_link_if i_rrl_link_if ();
  rrl_ctl_end #(.P_RFCAB(RFAB), .P_RFCPB(RFPB)) i_rrl_ctl_end (
    .i_clk(i_clk), .i_rst(i_rst), .i_bl32(i_bl32),
    .i_req_valid(i_req_valid), .i_req_cmd(i_req_cmd),
    .i_req_bank(i_req_bank), .o_req_ready(rdy), .o_bank_open(c_open),
    .o_ref_done(c_done), .o_bank_cnt(c_cnt), .link(i_rrl_link_if));
  rrl_dev_end #(.P_RAS(RAS), .P_RFCAB(RFAB), .P_RFCPB(RFPB))
  i_rrl_dev_end (
    .i_clk(i_clk), .i_rst(i_rst), .i_mr_nrtp(8'h08), .i_mr_nwr(i_mr_nwr),
    .o_bank_open(d_open), .o_bank_busy(d_busy), .o_ref_pulse(pulse),
    .o_ref_all(all), .o_ref_bank(bank), .o_ref_row(row),
    .o_bank_cnt(d_cnt), .link(i_rrl_link_if));
  rrl_chk i_rrl_chk (
    .i_clk(i_clk), .i_rst(i_rst), .ck(i_rrl_link_if.ck),
    .cs(i_rrl_link_if.cs), .ca(i_rrl_link_if.ca), .o_ref_pulse(pulse),
    .o_ref_all(all), .o_ref_bank(bank), .o_ref_row(row),
    .o_bank_cnt(d_cnt));

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // Request held until taken or the limit runs out
  task automatic issue(input rrl_cmd_type c, input logic [2:0] b,
                       input int lim, output bit ok);
    ok = 1'b0;
    @(negedge i_clk);
    i_req_cmd = c;
    i_req_bank = b;
    i_req_valid = 1'b1;
    for (int n = 0; n < lim && !ok; n++) begin
      #1;
      ok = (rdy === 1'b1);
      if (!ok) @(negedge i_clk);
    end
    if (ok) t_acc = cyc;
    if (ok) @(negedge i_clk);
    i_req_valid = 1'b0;
  endtask : issue

  task automatic wait_ref();
    for (int n = 0; n < 40; n++) begin
      @(negedge i_clk);
      if (pulse === 1'b1) return;
    end
    check("ref_pulse", 32'h0, 32'h1);
  endtask : wait_ref

  // ==========================================================
  // Sequence
  // ==========================================================
  initial begin
    #(25 * 20000);
    err_total++;
    summarize();
  end

  initial begin
    bit         ok;
    logic [7:0] m;
    int         t_prev;
    int         lo;
    int         hi;
    m = 8'h00;
    t_prev = 0;
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    for (int i = 0; i < NR; i++) begin
      issue(i == 19 ? C_REFAB : C_REFPB, 3'(bk[i]), 200, ok);
      if (i == 20) check("gap_ab", 32'(t_acc - t_prev >= RFAB), 32'h1);
      else if (i > 0) check("gap_pb", 32'(t_acc - t_prev >= RFPB), 32'h1);
      t_prev = t_acc;
      wait_ref();
      check("ref_all", 32'(all), 32'(i == 19));
      check("ref_row", 32'(row), 32'(erow[i]));
      if (i != 19) check("ref_bank", 32'(bank), 32'(bk[i]));
      if (i != 19) check("busy", 32'(d_busy[bk[i]]), 32'h1);
      m = m | (8'h01 << bk[i]);
      if (i == 19 || m == 8'hFF) m = 8'h00;
      repeat (2) @(negedge i_clk);
      check("dev_cnt", 32'(d_cnt), 32'(ecnt[i]));
      check("ctl_cnt", 32'(c_cnt), 32'(ecnt[i]));
      check("done", 32'(c_done), 32'(m));
    end
    issue(C_REFPB, 3'h7, 100, ok);
    check("dup_ref", 32'(ok), 32'h0);
    issue(C_SRX, 3'h0, 200, ok);
    repeat (20) @(negedge i_clk);
    check("srx_dev", 32'(d_cnt), 32'h0);
    check("srx_ctl", 32'(c_cnt), 32'h0);
    issue(C_REFPB, 3'h0, 200, ok);
    wait_ref();
    i_rst = 1'b1;
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    check("rst_dev", 32'(d_cnt), 32'h0);
    check("rst_ctl", 32'(c_cnt), 32'h0);
    // Early auto-precharge: read held by the lock, write by nWR
    for (int k = 0; k < 2; k++) begin
      i_mr_nwr = k ? 8'h28 : 8'h08;
      i_bl32 = (k == 1);
      lo = k ? 160 : RAS;
      hi = k ? 190 : RAS + 4;
      dur = 0;
      issue(C_ACT, 3'h2, 200, ok);
      check("ctl_open", 32'(c_open[2]), 32'h1);
      issue(k ? C_WRA : C_RDA, 3'h2, 200, ok);
      check("ctl_ap_closed", 32'(c_open[2]), 32'h0);
      for (int n = 0; n < 400 && !(dur > 0 && d_open[2] === 1'b0); n++)
        @(negedge i_clk);
      check("ap_delay", 32'(dur >= lo && dur <= hi), 32'h1);
    end
    summarize();
  end
endmodule : refresh_and_ras_lock_logic_test
